/* File: rule_exec_output.sv */
// Purpose: Logic, execution and output stages of one condition rule
// Assumes: cond_in from pins; cascade_in from the adjacent rule, same clock
// Notes: Registers over Avalon-MM; slot actions leave as one-cycle pulses, except in full-speed mode where they repeat every cycle
`timescale 1ns/10ps
module rule_exec_output import rule_exec_pkg::*; #(
  parameter int N_SLOT = SLOT_COUNT,
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] cond_in,
  input wire logic cascade_in,
  output logic cascade_out,
  output logic [N_SLOT-1:0] act_valid,
  output logic [N_SLOT-1:0] net_req,
  output logic [N_SLOT*4-1:0] act_type,
  output logic [N_SLOT*4-1:0] act_ip,
  output logic [N_SLOT*4-1:0] act_chan,
  output logic [N_SLOT*2-1:0] act_code,
  output logic [N_SLOT*3-1:0] act_range,
  output logic [N_SLOT*VAL_W-1:0] act_value,
  output logic verify_req,
  output logic [SLOT_W-1:0] verify_cfg,
  input wire logic verify_ack,
  input wire logic verify_ok
);
  localparam int MSW = $clog2(MS_CYCLES + 1);
  // ***********************************************
  // Register bus
  // ***********************************************
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [PERIOD_W-1:0] period_q, period_d;
  logic [SLOT_W-1:0] slot_cfg_q [N_SLOT], slot_cfg_d [N_SLOT];
  logic [VAL_W-1:0] slot_val_q [N_SLOT], slot_val_d [N_SLOT];
  logic wr_go, vfy_start;
  logic [1:0] vfy_sel;
  logic result, fwd_q, fwd_val_q;
  logic vfy_done_q, vfy_ok_q;
  verify_state_e vst_q;
  // Answer one cycle after the request is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
  assign wr_go = avs_write & ack_q;
  assign vfy_sel = avs_writedata[1:0];
  assign vfy_start = wr_go && avs_address == OFS_VERIFY && vfy_sel < 2'(N_SLOT) && vst_q == V_IDLE;
  // Decode, read mux and register writes
  always_comb begin
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    period_d = period_q;
    slot_cfg_d = slot_cfg_q;
    slot_val_d = slot_val_q;
    if (avs_read && !ack_q) begin
      rdata_d = 32'h00000000;
      if (avs_address == OFS_CTRL) rdata_d = 32'(ctrl_q);
      if (avs_address == OFS_PERIOD) rdata_d = 32'(period_q);
      if (avs_address == OFS_STATUS) begin
        rdata_d = 32'({vst_q, vfy_ok_q, vfy_done_q, fwd_val_q, result});
      end
      for (int i = 0; i < N_SLOT; i++) begin
        if (avs_address == AW'(OFS_SLOT0 + SLOT_STEP * i)) rdata_d = 32'(slot_cfg_q[i]);
        if (avs_address == AW'(OFS_VAL0 + SLOT_STEP * i)) rdata_d = 32'(slot_val_q[i]);
      end
    end
    if (wr_go) begin
      if (avs_address == OFS_CTRL) ctrl_d = avs_writedata[CTRL_W-1:0];
      // Clamp the period into the legal millisecond span
      if (avs_address == OFS_PERIOD) begin
        period_d = avs_writedata[PERIOD_W-1:0];
        if (avs_writedata[PERIOD_W-1:0] < PERIOD_MIN_MS) period_d = PERIOD_MIN_MS;
        if (avs_writedata[PERIOD_W-1:0] > PERIOD_MAX_MS) period_d = PERIOD_MAX_MS;
      end
      for (int i = 0; i < N_SLOT; i++) begin
        if (avs_address == AW'(OFS_SLOT0 + SLOT_STEP * i)) begin
          slot_cfg_d[i] = avs_writedata[SLOT_W-1:0];
        end
        if (avs_address == AW'(OFS_VAL0 + SLOT_STEP * i)) begin
          slot_val_d[i] = avs_writedata[VAL_W-1:0];
        end
      end
    end
  end
  // Bus registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q <= CTRL_RST;
      period_q <= PERIOD_RST;
      slot_cfg_q <= '{default: SLOT_RST};
      slot_val_q <= '{default: '0};
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      period_q <= period_d;
      slot_cfg_q <= slot_cfg_d;
      slot_val_q <= slot_val_d;
    end
  end
  // ***********************************************
  // Logic stage
  // ***********************************************
  logic [2:0] cond_meta_q, cond_sync_q;
  logic [2:0] cond, mask;
  logic run, cascade, full;
  assign run = ctrl_q[CTRL_RUN_BIT];
  assign cascade = ctrl_q[CTRL_CASCADE_BIT];
  assign full = ctrl_q[CTRL_FULL_BIT];
  assign mask = ctrl_q[CTRL_MASK_LSB+:3];
  // Two-stage synchroniser for the condition pins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cond_meta_q <= 3'h0;
      cond_sync_q <= 3'h0;
    end else begin
      cond_meta_q <= cond_in;
      cond_sync_q <= cond_meta_q;
    end
  end
  // Condition 0 may come from the neighbouring rule instead
  always_comb begin
    cond = cond_sync_q;
    if (ctrl_q[CTRL_CIN_BIT]) cond[0] = cascade_in;
    unique case (logic_op_e'(ctrl_q[CTRL_OP_LSB+:2]))
      OP_AND: result = (mask != 3'h0) && (&(cond | ~mask));
      OP_OR: result = |(cond & mask);
      OP_NAND: result = !((mask != 3'h0) && (&(cond | ~mask)));
      OP_NOR: result = !(|(cond & mask));
    endcase
  end
  // ***********************************************
  // Execution stage
  // ***********************************************
  logic [MSW-1:0] ms_cnt_q, ms_cnt_d;
  logic [PERIOD_W-1:0] per_cnt_q, per_cnt_d;
  logic fwd_d, fwd_val_d, cas_q, cas_d, tick, per_end;
  assign tick = ms_cnt_q == MSW'(MS_CYCLES - 1);
  assign per_end = per_cnt_q == period_q - PERIOD_MIN_MS;
  assign cascade_out = cas_q;
  // Millisecond timebase, period count and forward strobe
  always_comb begin
    ms_cnt_d = tick ? '0 : ms_cnt_q + 1'b1;
    per_cnt_d = per_cnt_q;
    if (tick) per_cnt_d = per_end ? '0 : per_cnt_q + 1'b1;
    if (!run || cascade || full) begin
      ms_cnt_d = '0;
      per_cnt_d = '0;
    end
    fwd_d = run && !cascade && (full || (tick && per_end));
    fwd_val_d = fwd_d ? result : fwd_val_q;
    cas_d = run && cascade && result;
  end
  // Execution registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q <= '0;
      per_cnt_q <= '0;
      fwd_q <= 1'b0;
      fwd_val_q <= 1'b0;
      cas_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_cnt_d;
      per_cnt_q <= per_cnt_d;
      fwd_q <= fwd_d;
      fwd_val_q <= fwd_val_d;
      cas_q <= cas_d;
    end
  end
  // ***********************************************
  // Output stage
  // ***********************************************
  logic [N_SLOT-1:0] act_valid_d, net_req_d;
  logic [N_SLOT*4-1:0] act_type_d, act_ip_d, act_chan_d;
  logic [N_SLOT*2-1:0] act_code_d;
  logic [N_SLOT*3-1:0] act_range_d;
  logic [N_SLOT*VAL_W-1:0] act_value_d;
  // Every slot sees the same forwarded result
  always_comb begin
    logic [SLOT_W-1:0] cfg;
    logic [1:0] tact, code;
    logic go;
    cfg = '0;
    tact = '0;
    code = '0;
    go = 1'b0;
    act_type_d = act_type;
    act_ip_d = act_ip;
    act_chan_d = act_chan;
    act_code_d = act_code;
    act_range_d = act_range;
    act_value_d = act_value;
    for (int i = 0; i < N_SLOT; i++) begin
      cfg = slot_cfg_q[i];
      tact = cfg[SL_TACT_LSB+:2];
      code = 2'b00;
      go = 1'b0;
      case (slot_type_e'(cfg[SL_TYPE_LSB+:4]))
        idle_slot_type: go = 1'b0;
        analog_output_action: begin
          go = fwd_val_q;
          code = CODE_WRITE;
        end
        digital_output: begin
          go = 1'b1;
          code = {1'b0, fwd_val_q ? tact[0] : ~tact[0]};
        end
        counter_channel_control: begin
          go = tact != CNT_NONE;
          code = tact;
          if (!fwd_val_q) begin
            unique case (cnt_act_e'(tact))
              CNT_START: code = CNT_STOP;
              CNT_STOP: code = CNT_START;
              CNT_RESET, CNT_NONE: go = 1'b0;
            endcase
          end
        end
        default: go = 1'b0;
      endcase
      // Remote slots leave as network requests, local as actions
      act_valid_d[i] = fwd_q && go && !cfg[SL_REMOTE_BIT];
      net_req_d[i] = fwd_q && go && cfg[SL_REMOTE_BIT];
      if (fwd_q && go) begin
        act_type_d[i*4+:4] = cfg[SL_TYPE_LSB+:4];
        act_ip_d[i*4+:4] = cfg[SL_IP_LSB+:4];
        act_chan_d[i*4+:4] = cfg[SL_CHAN_LSB+:4];
        act_code_d[i*2+:2] = code;
        act_range_d[i*3+:3] = cfg[SL_RANGE_LSB+:3];
        act_value_d[i*VAL_W+:VAL_W] = slot_val_q[i];
      end
    end
  end
  // Slot action registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      act_valid <= '0;
      net_req <= '0;
      act_type <= '0;
      act_ip <= '0;
      act_chan <= '0;
      act_code <= '0;
      act_range <= '0;
      act_value <= '0;
    end else begin
      act_valid <= act_valid_d;
      net_req <= net_req_d;
      act_type <= act_type_d;
      act_ip <= act_ip_d;
      act_chan <= act_chan_d;
      act_code <= act_code_d;
      act_range <= act_range_d;
      act_value <= act_value_d;
    end
  end
  // ***********************************************
  // Target verification
  // ***********************************************
  verify_state_e vst_d;
  logic vfy_done_d, vfy_ok_d;
  logic [SLOT_W-1:0] vcfg_q, vcfg_d;
  assign verify_req = vst_q == V_WAIT;
  assign verify_cfg = vcfg_q;
  // Idle slots finish at once without a target check
  always_comb begin
    vst_d = vst_q;
    vfy_done_d = vfy_done_q;
    vfy_ok_d = vfy_ok_q;
    vcfg_d = vcfg_q;
    unique case (vst_q)
      V_IDLE: begin
        if (vfy_start) begin
          vcfg_d = slot_cfg_q[vfy_sel];
          vfy_done_d = 1'b0;
          vfy_ok_d = 1'b0;
          if (slot_cfg_q[vfy_sel][SL_TYPE_LSB+:4] == idle_slot_type) begin
            vfy_done_d = 1'b1;
            vfy_ok_d = 1'b1;
          end else begin
            vst_d = V_WAIT;
          end
        end
      end
      V_WAIT: begin
        if (verify_ack) begin
          vst_d = V_IDLE;
          vfy_done_d = 1'b1;
          vfy_ok_d = verify_ok;
        end
      end
    endcase
  end
  // Verification registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      vst_q <= V_IDLE;
      vfy_done_q <= 1'b0;
      vfy_ok_q <= 1'b0;
      vcfg_q <= SLOT_RST;
    end else begin
      vst_q <= vst_d;
      vfy_done_q <= vfy_done_d;
      vfy_ok_q <= vfy_ok_d;
      vcfg_q <= vcfg_d;
    end
  end
  // ***********************************************
  // Assertions
  // ***********************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence fwd_seen;
    fwd_q && !$changed(slot_cfg_q[0]);
  endsequence
  sequence idle_verify;
    vfy_start && vfy_sel == 2'b00 && slot_cfg_q[0][3:0] == idle_slot_type;
  endsequence
  AST_LOGIC_AND: assert property (ctrl_q[1:0] == OP_AND && mask == 3'h7
    |-> result == &cond) else $error("AND result wrong");
  AST_FULL_SPEED: assert property (run && full && !cascade |=> fwd_q)
    else $error("full speed did not forward");
  AST_CASCADE: assert property (run && cascade |=> cascade_out == $past(result)
    && !fwd_q) else $error("cascade output wrong");
  AST_IDLE_SILENT: assert property (fwd_seen ##0 slot_cfg_q[0][3:0] == idle_slot_type
    |=> !act_valid[0] && !net_req[0]) else $error("idle slot acted");
  AST_AO_FALSE: assert property (fwd_seen ##0 slot_cfg_q[0][3:0] == analog_output_action
    && !fwd_val_q |=> !act_valid[0] && !net_req[0]) else $error("analog acted on false");
  AST_DO_LEVEL: assert property (fwd_seen ##0 slot_cfg_q[0][3:0] == digital_output
    && !slot_cfg_q[0][SL_REMOTE_BIT] |=> act_valid[0]
    && act_code[0] == ($past(fwd_val_q) ~^ $past(slot_cfg_q[0][SL_TACT_LSB])))
    else $error("digital level wrong");
  AST_CNT_RESET: assert property (fwd_seen ##0 slot_cfg_q[0][3:0] == counter_channel_control
    && !fwd_val_q && slot_cfg_q[0][SL_TACT_LSB+:2] == CNT_RESET |=> !act_valid[0] && !net_req[0])
    else $error("reset acted on false");
  AST_REMOTE: assert property (net_req[0] |-> !act_valid[0]
    && $past(slot_cfg_q[0][SL_REMOTE_BIT])) else $error("remote slot acted locally");
  AST_VERIFY_IDLE: assert property (idle_verify |=> vfy_done_q && !verify_req
    ##1 !verify_req) else $error("idle slot was verified");
  AST_PERIOD_GAP: assert property (fwd_q && !full |=> !fwd_q)
    else $error("period forward twice in a row");
endmodule

/* File: rule_exec_pkg.sv */
// Purpose: Shared constants for the rule execution and output stage
// Assumes: Avalon-MM byte addresses, 32-bit data, 125 MHz mclk
// Notes: Register offsets, field positions and codes are defined here; the bench, model and assertions also repeat some as literals
package rule_exec_pkg;
  // ***********************************************
  // Bus and register map
  // ***********************************************
  localparam int AW = 6;
  localparam logic [AW-1:0] OFS_CTRL = 6'h00;
  localparam logic [AW-1:0] OFS_PERIOD = 6'h04;
  localparam logic [AW-1:0] OFS_SLOT0 = 6'h08;
  localparam logic [AW-1:0] OFS_VAL0 = 6'h14;
  localparam logic [AW-1:0] OFS_STATUS = 6'h20;
  localparam logic [AW-1:0] OFS_VERIFY = 6'h24;
  localparam int SLOT_STEP = 4;
  // Control fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_MASK_LSB = 2;
  localparam int CTRL_CASCADE_BIT = 5;
  localparam int CTRL_FULL_BIT = 6;
  localparam int CTRL_RUN_BIT = 7;
  localparam int CTRL_CIN_BIT = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h01c;
  // Slot configuration fields
  localparam int SL_TYPE_LSB = 0;
  localparam int SL_REMOTE_BIT = 4;
  localparam int SL_IP_LSB = 5;
  localparam int SL_CHAN_LSB = 9;
  localparam int SL_TACT_LSB = 13;
  localparam int SL_RANGE_LSB = 15;
  localparam int SLOT_W = 18;
  localparam logic [SLOT_W-1:0] SLOT_RST = 18'h00000;
  localparam int VAL_W = 16;
  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
  localparam int PERIOD_W = 16;
  localparam logic [PERIOD_W-1:0] PERIOD_MIN_MS = 16'h0001;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX_MS = 16'hea60;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h03e8;
  localparam int SLOT_COUNT = 3;
  // ***********************************************
  // Enumerations
  // ***********************************************
  typedef enum logic [1:0] {
    OP_AND = 2'b00, OP_OR = 2'b01, OP_NAND = 2'b10, OP_NOR = 2'b11
  } logic_op_e;
  typedef enum logic [3:0] {
    idle_slot_type = 4'h0, analog_output_action = 4'h1, digital_output = 4'h2,
    counter_channel_control = 4'h3, pulse_output = 4'h4, timer_action = 4'h5,
    internal_flag_action = 4'h6, network_message_action = 4'h7,
    internal_counter = 4'h8
  } slot_type_e;
  typedef enum logic [1:0] {
    CNT_START = 2'b00, CNT_STOP = 2'b01, CNT_RESET = 2'b10, CNT_NONE = 2'b11
  } cnt_act_e;
  localparam logic [1:0] CODE_WRITE = 2'b01;
  typedef enum logic {V_IDLE = 1'b0, V_WAIT = 1'b1} verify_state_e;
endpackage

/* File: remote_io_model.sv */
// Purpose: Far-side network model that answers target checks
// Assumes: Same clock as the rule block; delay and outcome set by the bench
// Notes: The ok line wanders while no answer is given
`timescale 1ns/10ps
module remote_io_model import rule_exec_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic verify_req,
  input wire logic [SLOT_W-1:0] verify_cfg,
  input wire logic [2:0] lat,
  input wire logic give_ok,
  output logic verify_ack,
  output logic verify_ok
);
  logic [2:0] wait_q;
  logic done_q;
  // One answer per check, lat+1 cycles after the request rises
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q <= 3'h0;
      done_q <= 1'b0;
      verify_ack <= 1'b0;
      verify_ok <= 1'b0;
    end else begin
      verify_ack <= 1'b0;
      verify_ok <= ~verify_ok;
      if (!verify_req) begin
        wait_q <= 3'h0;
        done_q <= 1'b0;
      end else if (!done_q && wait_q == lat) begin
        verify_ack <= 1'b1;
        verify_ok <= give_ok & (verify_cfg[3:0] != 4'h0);
        done_q <= 1'b1;
      end else if (!done_q) begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the rule execution and output stage
// Assumes: ms tick shortened to four cycles; far side from remote_io_model
// Notes: Corner rounds first, then random slot setups from a fixed seed
`timescale 1ns/10ps
module testbench;
  import rule_exec_pkg::*;
  localparam int MSC = 4;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, cascade_out, verify_req, verify_ack, verify_ok, exp_res, vseen;
  logic [2:0] cond_in = 3'h0;
  logic cascade_in = 1'b0;
  logic [2:0] lat = 3'h1;
  logic give_ok = 1'b1;
  logic [2:0] act_valid, net_req, e, e2, c, m;
  logic [11:0] act_type, act_ip, act_chan;
  logic [5:0] act_code;
  logic [8:0] act_range;
  logic [47:0] act_value;
  logic [SLOT_W-1:0] verify_cfg;
  logic [SLOT_W-1:0] cfg [3];
  logic [15:0] val [3];
  logic [1:0] op;
  int mismatches = 0;
  int checked = 0;
  int seed = 32'hba39;
  int npulse [3];
  int cyc_n = 0;
  int last0 = 0;
  int gap = 0;
  int n, p;

  rule_exec_output #(.N_SLOT(3), .MS_CYCLES(MSC)) i_dut (.mclk(mclk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cond_in(cond_in), .cascade_in(cascade_in),
    .cascade_out(cascade_out), .act_valid(act_valid), .net_req(net_req),
    .act_type(act_type), .act_ip(act_ip), .act_chan(act_chan), .act_code(act_code),
    .act_range(act_range), .act_value(act_value), .verify_req(verify_req),
    .verify_cfg(verify_cfg), .verify_ack(verify_ack), .verify_ok(verify_ok));
  remote_io_model i_far (.mclk(mclk), .reset_n(reset_n), .verify_req(verify_req),
    .verify_cfg(verify_cfg), .lat(lat), .give_ok(give_ok), .verify_ack(verify_ack),
    .verify_ok(verify_ok));

  // Clock
  always #4 mclk = ~mclk;

  // ***********************************************
  // Helpers
  // ***********************************************
  task automatic cmp(input string w, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, x, g);
    end
  endtask
  task automatic summarize;
    $display("Counts: checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 16);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 16) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] x, input string w);
    bus(1'b0, a, 32'h0);
    cmp(w, x, rd);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] o, input logic [2:0] k,
                                      input logic cs, fs, rn, ci);
    return {23'h0, ci, rn, fs, cs, k, o};
  endfunction
  function automatic logic res(input logic [1:0] o, input logic [2:0] k, input logic [2:0] v);
    logic a;
    logic y;
    a = &(v | ~k);
    y = |(v & k);
    return o[1] ^ (o[0] ? y : a);
  endfunction
  // Expected {acts, code} for one slot and one result
  function automatic logic [2:0] ecode(input logic [SLOT_W-1:0] s, input logic r);
    logic [1:0] t;
    t = s[SL_TACT_LSB+:2];
    case (s[3:0])
      4'h1: return r ? {1'b1, CODE_WRITE} : 3'b000;
      4'h2: return {2'b10, r ~^ t[0]};
      4'h3: return r ? {1'b1, t} : (t == CNT_RESET ? 3'b000 : {2'b10, ~t[0]});
      default: return 3'b000;
    endcase
  endfunction
  task automatic setslot(input int i, input logic [SLOT_W-1:0] s, input logic [15:0] v);
    cfg[i] = s;
    val[i] = v;
    wr(OFS_SLOT0 + AW'(SLOT_STEP * i), 32'(s));
    wr(OFS_VAL0 + AW'(SLOT_STEP * i), 32'(v));
    rdc(OFS_SLOT0 + AW'(SLOT_STEP * i), 32'(s), "slot");
  endtask
  task automatic vcheck(input int s, input logic ok, input logic [2:0] l);
    int k;
    lat <= l;
    give_ok <= ok;
    vseen = 1'b0;
    wr(OFS_VERIFY, 32'(s));
    k = 0;
    while (verify_req !== 1'b1 && k < 8 && cfg[s][3:0] != 4'h0) begin
      cyc(1);
      k++;
    end
    if (k >= 8) begin
      mismatches++;
      summarize();
    end
    if (cfg[s][3:0] != 4'h0) cmp("vcfg", cfg[s], verify_cfg);
    cyc(12);
    bus(1'b0, OFS_STATUS, 32'h0);
    cmp("vreq", cfg[s][3:0] != 4'h0, vseen);
    cmp("vstat", {1'b0, cfg[s][3:0] == 4'h0 || ok, 1'b1}, rd[4:2]);
  endtask

  // Every slot action is checked against the bench's slot setup
  always @(posedge mclk) begin
    cyc_n++;
    if (verify_req === 1'b1) vseen = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (act_valid[i] === 1'b1 || net_req[i] === 1'b1) begin
        npulse[i]++;
        e = ecode(cfg[i], exp_res);
        if (i == 0) begin
          gap = cyc_n - last0;
          last0 = cyc_n;
        end
        cmp("acts", 1, e[2]);
        cmp("route", {cfg[i][SL_REMOTE_BIT], ~cfg[i][SL_REMOTE_BIT]},
            {net_req[i], act_valid[i]});
        cmp("type", cfg[i][3:0], act_type[i*4+:4]);
        cmp("ip", cfg[i][SL_IP_LSB+:4], act_ip[i*4+:4]);
        cmp("chan", cfg[i][SL_CHAN_LSB+:4], act_chan[i*4+:4]);
        if (cfg[i][3:0] == 4'h2) cmp("level", e[0], act_code[i*2]);
        else cmp("code", e[1:0], act_code[i*2+:2]);
        if (cfg[i][3:0] == 4'h1) begin
          cmp("value", val[i], act_value[i*16+:16]);
          cmp("range", cfg[i][SL_RANGE_LSB+:3], act_range[i*3+:3]);
        end
      end
    end
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    summarize();
  end

  // ***********************************************
  // Main sequence
  // ***********************************************
  initial begin
    for (int i = 0; i < 3; i++) begin
      cfg[i] = '0;
      val[i] = '0;
      npulse[i] = 0;
    end
    exp_res = 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    rdc(OFS_CTRL, CTRL_RST, "ctrl");
    rdc(OFS_PERIOD, PERIOD_RST, "period");
    rdc(OFS_SLOT0, SLOT_RST, "slot0");
    wr(6'h3c, 32'hffffffff);
    rdc(6'h3c, 32'h0, "unmapped");
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      c = 3'($random(seed));
      m = 3'(({$random(seed)} % 7) + 1);
      cond_in <= c;
      wr(OFS_CTRL, ctl(2'(k), m, 1'b0, 1'b0, 1'b0, 1'b0));
      cyc(4);
      bus(1'b0, OFS_STATUS, 32'h0);
      cmp("result", res(2'(k), m, c), rd[0]);
    end
    $display("test logic done");
    wr(OFS_PERIOD, 32'h1);
    for (int r = 0; r < 10; r++) begin
      for (int i = 0; i < 3; i++) begin
        c = 3'($random(seed));
        setslot(i, {c, r < 6 ? 2'(r % 3) : 2'({$random(seed)} % 3), 9'($random(seed)),
                    r < 6 ? 4'(i + 1) : 4'({$random(seed)} % 9)}, 16'($random(seed)));
      end
      c = (r < 6) ? {3{~r[0]}} : 3'($random(seed));
      m = (r < 6) ? 3'h7 : 3'(({$random(seed)} % 7) + 1);
      op = (r < 6) ? 2'h0 : 2'($random(seed));
      cond_in <= c;
      exp_res = res(op, m, c);
      wr(OFS_CTRL, ctl(op, m, 1'b0, 1'b0, 1'b1, 1'b0));
      cyc(40);
      wr(OFS_CTRL, ctl(op, m, 1'b0, 1'b0, 1'b0, 1'b0));
      cyc(4);
      for (int i = 0; i < 3; i++) begin
        e2 = ecode(cfg[i], exp_res);
        if (e2 == 3'b000) cmp("quiet", 0, npulse[i]);
        else if (e2 != 3'b111) cmp("fired", 1, npulse[i] > 4);
        npulse[i] = 0;
      end
      $display("test slots round %0d done", r);
    end
    setslot(0, 18'h00002, 16'h0);
    setslot(1, 18'h0, 16'h0);
    setslot(2, 18'h0, 16'h0);
    cond_in <= 3'h7;
    exp_res = 1'b1;
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 1 : (k == 1) ? 3 : 2 + {$random(seed)} % 5;
      wr(OFS_PERIOD, 32'(p));
      npulse[0] = 0;
      wr(OFS_CTRL, ctl(2'h0, 3'h7, 1'b0, 1'b0, 1'b1, 1'b0));
      n = 0;
      while (npulse[0] < 3 && n < 200) begin
        cyc(1);
        n++;
      end
      if (n >= 200) begin
        mismatches++;
        summarize();
      end
      cmp("gap", p * MSC, gap);
      wr(OFS_CTRL, ctl(2'h0, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0));
      cyc(4);
    end
    npulse[0] = 0;
    wr(OFS_CTRL, ctl(2'h0, 3'h7, 1'b0, 1'b1, 1'b1, 1'b0));
    cyc(14);
    wr(OFS_CTRL, ctl(2'h0, 3'h7, 1'b0, 1'b0, 1'b0, 1'b0));
    cyc(4);
    cmp("full", 1, npulse[0] > 11);
    wr(OFS_PERIOD, 32'h0);
    rdc(OFS_PERIOD, PERIOD_MIN_MS, "pmin");
    wr(OFS_PERIOD, 32'hffff);
    rdc(OFS_PERIOD, PERIOD_MAX_MS, "pmax");
    $display("test period done");
    npulse[0] = 0;
    cond_in <= 3'h6;
    for (int k = 0; k < 4; k++) begin
      cascade_in <= k[0];
      wr(OFS_CTRL, ctl(2'h0, 3'h1, 1'b1, 1'b0, 1'b1, 1'b1));
      cyc(6);
      cmp("cascade", k[0], cascade_out);
    end
    cmp("cas_quiet", 0, npulse[0]);
    wr(OFS_CTRL, ctl(2'h0, 3'h1, 1'b0, 1'b0, 1'b1, 1'b1));
    cyc(3);
    cmp("no_cas", 0, cascade_out);
    wr(OFS_CTRL, ctl(2'h0, 3'h1, 1'b0, 1'b0, 1'b0, 1'b0));
    cyc(4);
    $display("test cascade done");
    setslot(0, 18'h0, 16'h0);
    setslot(1, 18'h00403, 16'h0);
    vcheck(0, 1'b1, 3'h2);
    vcheck(1, 1'b1, 3'h2);
    vcheck(1, 1'b0, 3'h5);
    $display("test verify done");
    summarize();
  end
endmodule
